//--- rtl/jdp_scan.sv
// scan chains, debug port registers and access-port launch of the debug port
`timescale 1ns/1ps
`include "jdp_cfg.svh"

module jdp_scan import jdp_pkg::*; #(
    parameter logic [31:0] IDCODE_VAL = 32'h0000_0001, // arbitrary
    parameter logic [31:0] DP_ID_VAL = 32'h0000_0001, // arbitrary
    parameter logic [31:0] DP_ID_EXT_VAL = 32'h0000_0000, // arbitrary
    parameter logic [31:0] BASE_LO_VAL = 32'h0000_0000,
    parameter logic [31:0] BASE_HI_VAL = 32'h0000_0000,
    parameter logic [31:0] TARGET_ID_VAL = 32'h0000_0001, // arbitrary
    parameter logic [31:0] LINK_PID_VAL = 32'h0000_0001 // arbitrary
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic serial_data_in_pin_i,
    input wire logic tlr_i,
    input wire logic capture_ir_i,
    input wire logic shift_ir_i,
    input wire logic update_ir_i,
    input wire logic capture_dr_i,
    input wire logic shift_dr_i,
    input wire logic update_dr_i,
    input wire logic ap_done_i,
    input jdp_resp_t ap_resp_i,
    output logic serial_data_out_pin_o,
    output logic serial_data_out_oe_o,
    output logic ap_req_o,
    output jdp_req_t ap_cmd_o,
    output logic ap_abort_o
);

    logic [1:0] rst_s_ff;
    logic tck_rst;
    jdp_instr_t instr;
    logic ir_lsb;
    logic [`JDP_ACC_W-1:0] dr_sh_ff;
    logic [2:0] ack_ff;
    logic [31:0] read_buffer_ff;
    logic [31:0] ctrl;
    logic orun_ff;
    logic err_ff;
    logic [`JDP_CS_RW_HI:`JDP_CS_RW_LO] ctrl_rw_ff;
    logic wr_ctrl;
    logic [31:0] select_ff;
    logic [31:0] bank_select_ext_ff;
    logic [31:0] link_ctrl_ff;
    logic fault_next_ff;
    logic req_tgl_ff;
    logic abort_tgl_ff;
    logic pend_rd_ff;
    jdp_req_t req_ff;
    logic [2:0] ack_s_ff;
    logic ack_tgl;
    jdp_resp_t resp;
    logic busy;
    logic ack_edge;
    logic is_acc;
    logic sticky;
    logic [2:0] cap_ack;
    logic upd_ok;
    logic upd_dp;
    logic upd_ap;
    logic upd_abort;
    logic dr_rnw;
    logic [1:0] dr_addr;
    logic [31:0] dr_data;
    logic [3:0] bank;
    logic [31:0] dp_rd;
    logic set_orun;
    logic set_err;
    logic clr_orun;
    logic clr_err;

    // ==========================================
    // reset into tck domain
    always_ff @(posedge tck_i) begin
        rst_s_ff <= {rst_s_ff[0], rst_i};
    end

    assign tck_rst = rst_s_ff[1];

    // ==========================================
    // instruction register
    jdp_ir u_ir (
        .tck_i(tck_i),
        .rst_i(tck_rst),
        .tlr_i(tlr_i),
        .capture_i(capture_ir_i),
        .shift_i(shift_ir_i),
        .update_i(update_ir_i),
        .tdi_i(serial_data_in_pin_i),
        .instr_o(instr),
        .lsb_o(ir_lsb)
    );

    // ==========================================
    // decode of the shifted request
    assign is_acc = (instr == JDP_INS_DP_ACCESS_SCAN) || (instr == JDP_INS_ACCESSPORT_ACCESS_CHAIN);
    assign dr_rnw = dr_sh_ff[`JDP_RNW_BIT];
    assign dr_addr = dr_sh_ff[`JDP_DATA_LO-1:`JDP_ADDR_LO];
    assign dr_data = dr_sh_ff[`JDP_ACC_W-1:`JDP_DATA_LO];
    assign bank = select_ff[`JDP_BANKSEL_HI:0];
    assign sticky = orun_ff | err_ff;
    assign upd_ok = update_dr_i && is_acc && (ack_ff != `JDP_ACK_WAIT);
    assign upd_dp = upd_ok && (instr == JDP_INS_DP_ACCESS_SCAN);
    assign upd_ap = upd_ok && (instr == JDP_INS_ACCESSPORT_ACCESS_CHAIN);
    assign upd_abort = update_dr_i && (instr == JDP_INS_ABORT);

    // acknowledge chosen at capture
    always_comb begin
        if (busy) begin
            cap_ack = `JDP_ACK_WAIT;
        end else if (fault_next_ff || ((instr == JDP_INS_ACCESSPORT_ACCESS_CHAIN) && sticky)) begin
            cap_ack = `JDP_ACK_FAULT;
        end else begin
            cap_ack = `JDP_ACK_OK;
        end
    end

    // ==========================================
    // data register shift chain
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            dr_sh_ff <= '0;
        end else if (capture_dr_i) begin
            case (instr)
                JDP_INS_IDCODE: dr_sh_ff <= {3'h0, IDCODE_VAL};
                JDP_INS_DP_ACCESS_SCAN, JDP_INS_ACCESSPORT_ACCESS_CHAIN: dr_sh_ff <= {read_buffer_ff, cap_ack};
                default: dr_sh_ff <= '0;
            endcase
        end else if (shift_dr_i) begin
            case (instr)
                JDP_INS_BYPASS: dr_sh_ff <= {34'h0, serial_data_in_pin_i};
                JDP_INS_IDCODE: dr_sh_ff <= {3'h0, serial_data_in_pin_i,
                                             dr_sh_ff[`JDP_ID_W-1:1]};
                default: dr_sh_ff <= {serial_data_in_pin_i,
                                      dr_sh_ff[`JDP_ACC_W-1:1]};
            endcase
        end
    end

    // captured acknowledge steers the following update
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            ack_ff <= `JDP_ACK_OK;
        end else if (capture_dr_i && is_acc) begin
            ack_ff <= cap_ack;
        end
    end

    // ==========================================
    // serial output, changes on falling edge
    always_ff @(negedge tck_i) begin
        if (tck_rst) begin
            serial_data_out_pin_o <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        end else begin
            serial_data_out_oe_o <= shift_ir_i | shift_dr_i;
            serial_data_out_pin_o <= shift_ir_i ? ir_lsb : dr_sh_ff[0];
        end
    end

    // ==========================================
    // debug port read mux
    always_comb begin
        dp_rd = `JDP_RST32;
        case (dr_addr)
            `JDP_A_00: begin
                case (bank)
                    `JDP_BANK_0: dp_rd = DP_ID_VAL;
                    `JDP_BANK_1: dp_rd = DP_ID_EXT_VAL;
                    `JDP_BANK_2: dp_rd = BASE_LO_VAL;
                    `JDP_BANK_3: dp_rd = BASE_HI_VAL;
                    default: dp_rd = `JDP_RST32;
                endcase
            end
            `JDP_A_04: begin
                case (bank)
                    `JDP_BANK_0: dp_rd = ctrl;
                    `JDP_BANK_1: dp_rd = link_ctrl_ff;
                    `JDP_BANK_2: dp_rd = TARGET_ID_VAL;
                    `JDP_BANK_3: dp_rd = LINK_PID_VAL;
                    default: dp_rd = `JDP_RST32;
                endcase
            end
            `JDP_A_0C: dp_rd = read_buffer_ff;
            default: dp_rd = `JDP_RST32;
        endcase
    end

    // ==========================================
    // debug port writable registers
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            select_ff <= `JDP_RST32;
            bank_select_ext_ff <= `JDP_RST32;
            link_ctrl_ff <= `JDP_RST32;
        end else if (upd_dp && !dr_rnw) begin
            if (dr_addr == `JDP_A_08) begin
                select_ff <= dr_data;
            end else if (dr_addr == `JDP_A_04 && bank == `JDP_BANK_1) begin
                link_ctrl_ff <= dr_data;
            end else if (dr_addr == `JDP_A_04 && bank == `JDP_BANK_5) begin
                bank_select_ext_ff <= dr_data;
            end
        end
    end

    // ==========================================
    // control and status, sticky flags
    assign set_orun = capture_dr_i && is_acc && (cap_ack != `JDP_ACK_OK);
    assign set_err = ack_edge && resp.err;
    assign wr_ctrl = upd_dp && !dr_rnw && (dr_addr == `JDP_A_04) && (bank == `JDP_BANK_0);
    assign clr_orun = (wr_ctrl && dr_data[`JDP_CS_ORUN])
                      || (upd_abort && dr_data[`JDP_AB_ORUNCLR]);
    assign clr_err = (wr_ctrl && dr_data[`JDP_CS_ERR])
                     || (upd_abort && dr_data[`JDP_AB_ERRCLR]);

    // register view, unused bits read zero
    always_comb begin
        ctrl = `JDP_RST32;
        ctrl[`JDP_CS_ORUN] = orun_ff;
        ctrl[`JDP_CS_ERR] = err_ff;
        ctrl[`JDP_CS_RW_HI:`JDP_CS_RW_LO] = ctrl_rw_ff;
    end

    // sticky overrun, set wins over clear
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            orun_ff <= 1'b0;
        end else begin
            orun_ff <= (orun_ff & ~clr_orun) | set_orun;
        end
    end

    // sticky error, set wins over clear
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= (err_ff & ~clr_err) | set_err;
        end
    end

    // plain read-write field
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            ctrl_rw_ff <= '0;
        end else if (wr_ctrl) begin
            ctrl_rw_ff <= dr_data[`JDP_CS_RW_HI:`JDP_CS_RW_LO];
        end
    end

    // ==========================================
    // read result buffer
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            read_buffer_ff <= `JDP_RST32;
        end else if (upd_dp && dr_rnw && dr_addr != `JDP_A_0C) begin
            read_buffer_ff <= dp_rd;
        end else if (ack_edge && pend_rd_ff) begin
            read_buffer_ff <= resp.data;
        end
    end

    // ==========================================
    // access-port launch and abort
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            req_tgl_ff <= 1'b0;
            req_ff <= '0;
            pend_rd_ff <= 1'b0;
            fault_next_ff <= 1'b0;
        end else if (upd_ap) begin
            if (sticky) begin
                fault_next_ff <= 1'b1;
            end else begin
                req_ff <= '{data: dr_data, addr: dr_addr, read_not_write_bit: dr_rnw};
                pend_rd_ff <= dr_rnw;
                req_tgl_ff <= ~req_tgl_ff;
            end
        end else if (capture_dr_i && is_acc) begin
            fault_next_ff <= 1'b0;
        end
    end

    // abort toggle, flipped by an abort update with the DAP abort bit set
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            abort_tgl_ff <= 1'b0;
        end else if (upd_abort && dr_data[`JDP_AB_DAP]) begin
            abort_tgl_ff <= ~abort_tgl_ff;
        end
    end

    // ==========================================
    // completion back into tck domain
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            ack_s_ff <= 3'h0;
        end else begin
            ack_s_ff <= {ack_s_ff[1:0], ack_tgl};
        end
    end

    assign busy = req_tgl_ff ^ ack_s_ff[2];
    assign ack_edge = ack_s_ff[2] ^ ack_s_ff[1];

    jdp_ap_bridge u_bridge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_tgl_i(req_tgl_ff),
        .abort_tgl_i(abort_tgl_ff),
        .cmd_i(req_ff),
        .ap_done_i(ap_done_i),
        .ap_resp_i(ap_resp_i),
        .ap_req_o(ap_req_o),
        .ap_cmd_o(ap_cmd_o),
        .ap_abort_o(ap_abort_o),
        .ack_tgl_o(ack_tgl),
        .resp_o(resp)
    );

endmodule

//--- rtl/jdp_cfg.svh
// constants of the debug port scan chains
`ifndef JDP_CFG_SVH
`define JDP_CFG_SVH

// ==========================================
// instruction register
`define JDP_IR_W 4
`define JDP_IR_CAPTURE 4'h1
`define JDP_IR_ABORT 4'h8
`define JDP_IR_DP_ACCESS_SCAN 4'ha
`define JDP_IR_ACCESSPORT_ACCESS_CHAIN 4'hb
`define JDP_IR_IDCODE 4'he
`define JDP_IR_BYPASS 4'hf

// ==========================================
// data chains
`define JDP_ACC_W 35
`define JDP_ID_W 32
`define JDP_DATA_LO 3
`define JDP_ADDR_LO 1
`define JDP_RNW_BIT 0
`define JDP_ACK_WAIT 3'h1
`define JDP_ACK_FAULT 3'h2
`define JDP_ACK_OK 3'h4

// ==========================================
// debug port register map (address bits 3:2)
`define JDP_A_00 2'h0
`define JDP_A_04 2'h1
`define JDP_A_08 2'h2
`define JDP_A_0C 2'h3
`define JDP_BANK_0 4'h0
`define JDP_BANK_1 4'h1
`define JDP_BANK_2 4'h2
`define JDP_BANK_3 4'h3
`define JDP_BANK_4 4'h4
`define JDP_BANK_5 4'h5
`define JDP_BANKSEL_HI 3

// ==========================================
// field positions and reset values
`define JDP_CS_ORUN 1
`define JDP_CS_ERR 5
`define JDP_CS_RW_HI 31
`define JDP_CS_RW_LO 24
`define JDP_AB_DAP 0
`define JDP_AB_ERRCLR 2
`define JDP_AB_ORUNCLR 4
`define JDP_RST32 32'h0000_0000

`endif

//--- rtl/jdp_pkg.sv
// types shared by the debug port scan chain files
package jdp_pkg;

    // ==========================================
    // active instruction, one-hot
    typedef enum logic [4:0] {
        JDP_INS_ABORT = 5'h01,
        JDP_INS_DP_ACCESS_SCAN = 5'h02,
        JDP_INS_ACCESSPORT_ACCESS_CHAIN = 5'h04,
        JDP_INS_IDCODE = 5'h08,
        JDP_INS_BYPASS = 5'h10
    } jdp_instr_t;

    // ==========================================
    // access-port bridge state, one-hot
    typedef enum logic [1:0] {
        JDP_BR_IDLE = 2'h1,
        JDP_BR_BUSY = 2'h2
    } jdp_br_state_t;

    // ==========================================
    // access-port request and response
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] addr;
        logic read_not_write_bit;
    } jdp_req_t;

    typedef struct packed {
        logic err;
        logic [31:0] data;
    } jdp_resp_t;

endpackage

//--- rtl/jdp_ir.sv
// instruction register with shift stage and decoder
`timescale 1ns/1ps
`include "jdp_cfg.svh"

module jdp_ir import jdp_pkg::*; (
    input wire logic tck_i,
    input wire logic rst_i,
    input wire logic tlr_i,
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic update_i,
    input wire logic tdi_i,
    output jdp_instr_t instr_o,
    output logic lsb_o
);

    logic [`JDP_IR_W-1:0] sh_ff;
    logic [`JDP_IR_W-1:0] ir_ff;

    // ==========================================
    // shift stage
    always_ff @(posedge tck_i) begin
        if (rst_i) begin
            sh_ff <= `JDP_IR_CAPTURE;
        end else if (capture_i) begin
            sh_ff <= `JDP_IR_CAPTURE;
        end else if (shift_i) begin
            sh_ff <= {tdi_i, sh_ff[`JDP_IR_W-1:1]};
        end
    end

    // ==========================================
    // active instruction
    always_ff @(posedge tck_i) begin
        if (rst_i || tlr_i) begin
            ir_ff <= `JDP_IR_IDCODE;
        end else if (update_i) begin
            ir_ff <= sh_ff;
        end
    end

    // ==========================================
    // decoder
    always_comb begin
        case (ir_ff)
            `JDP_IR_ABORT: instr_o = JDP_INS_ABORT;
            `JDP_IR_DP_ACCESS_SCAN: instr_o = JDP_INS_DP_ACCESS_SCAN;
            `JDP_IR_ACCESSPORT_ACCESS_CHAIN: instr_o = JDP_INS_ACCESSPORT_ACCESS_CHAIN;
            `JDP_IR_IDCODE: instr_o = JDP_INS_IDCODE;
            default: instr_o = JDP_INS_BYPASS;
        endcase
    end

    assign lsb_o = sh_ff[0];

endmodule

//--- rtl/jdp_ap_bridge.sv
// system-clock side of access-port requests, toggle handshake from tck side
`timescale 1ns/1ps
`include "jdp_cfg.svh"

module jdp_ap_bridge import jdp_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_tgl_i,
    input wire logic abort_tgl_i,
    input jdp_req_t cmd_i,
    input wire logic ap_done_i,
    input jdp_resp_t ap_resp_i,
    output logic ap_req_o,
    output jdp_req_t ap_cmd_o,
    output logic ap_abort_o,
    output logic ack_tgl_o,
    output jdp_resp_t resp_o
);

    logic [2:0] req_s_ff;
    logic [2:0] abt_s_ff;
    logic req_edge;
    logic abt_edge;
    jdp_br_state_t state_ff;

    // ==========================================
    // synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_s_ff <= 3'h0;
            abt_s_ff <= 3'h0;
        end else begin
            req_s_ff <= {req_s_ff[1:0], req_tgl_i};
            abt_s_ff <= {abt_s_ff[1:0], abort_tgl_i};
        end
    end

    assign req_edge = req_s_ff[2] ^ req_s_ff[1];
    assign abt_edge = abt_s_ff[2] ^ abt_s_ff[1];

    // ==========================================
    // request sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= JDP_BR_IDLE;
            ap_req_o <= 1'b0;
            ap_cmd_o <= '0;
            ack_tgl_o <= 1'b0;
            resp_o <= '0;
        end else begin
            case (state_ff)
                JDP_BR_IDLE: begin
                    if (req_edge) begin
                        ap_req_o <= 1'b1;
                        ap_cmd_o <= cmd_i;
                        state_ff <= JDP_BR_BUSY;
                    end
                end
                JDP_BR_BUSY: begin
                    if (abt_edge || ap_done_i) begin
                        ap_req_o <= 1'b0;
                        resp_o <= ap_done_i ? ap_resp_i : '0;
                        ack_tgl_o <= ~ack_tgl_o;
                        state_ff <= JDP_BR_IDLE;
                    end
                end
                default: begin
                    state_ff <= JDP_BR_IDLE;
                    ap_req_o <= 1'b0;
                end
            endcase
        end
    end

    // abort pulse to the access port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ap_abort_o <= 1'b0;
        end else begin
            ap_abort_o <= abt_edge;
        end
    end

endmodule

//--- tb/jdp_scan_monitor.sv
// concurrent checks at the ports of the debug port scan chains
`timescale 1ns/1ps

module jdp_scan_monitor
    import jdp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic capture_ir_i,
    input wire logic shift_ir_i,
    input wire logic shift_dr_i,
    input wire logic ap_done_i,
    input wire logic serial_data_out_pin_o,
    input wire logic serial_data_out_oe_o,
    input wire logic ap_req_o,
    input jdp_req_t ap_cmd_o,
    input wire logic ap_abort_o
);
    // ==========================================
    // link side
    sequence ir_cap_shift;
        capture_ir_i ##1 shift_ir_i;
    endsequence
    ir_one_a: assert property (@(posedge tck_i) disable iff (rst_i)
        capture_ir_i |=> serial_data_out_pin_o) else $error("ir capture lsb not one");
    ir_zero_a: assert property (@(posedge tck_i) disable iff (rst_i)
        ir_cap_shift |=> !serial_data_out_pin_o) else $error("ir second bit not zero");
    oe_follow_a: assert property (@(negedge tck_i) disable iff (rst_i)
        serial_data_out_oe_o == $past(shift_ir_i || shift_dr_i))
        else $error("output enable not following shift");
    // ==========================================
    // access port side
    sequence req_waiting;
        ap_req_o && !ap_done_i;
    endsequence
    req_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_waiting |=> ap_req_o || ap_abort_o) else $error("request dropped before done");
    done_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ap_req_o && ap_done_i |=> !ap_req_o) else $error("request held after done");
    cmd_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ap_req_o && $past(ap_req_o) |-> $stable(ap_cmd_o)) else $error("command moved");
    abort_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ap_abort_o |=> !ap_abort_o) else $error("abort longer than one cycle");
    abort_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ap_abort_o |-> ##[0:2] !ap_req_o) else $error("abort left request pending");
endmodule

bind jdp_scan jdp_scan_monitor jdp_scan_monitor_i (.clk_i, .rst_i, .tck_i, .capture_ir_i,
    .shift_ir_i, .shift_dr_i, .ap_done_i, .serial_data_out_pin_o, .serial_data_out_oe_o,
    .ap_req_o, .ap_cmd_o, .ap_abort_o);

//--- tb/jdp_host.sv
// debugger model driving the test port states and serial lines
`timescale 1ns/1ps

module jdp_host (
    output logic tck_o,
    output logic tdi_o,
    output logic tlr_o,
    output logic cap_ir_o,
    output logic sh_ir_o,
    output logic up_ir_o,
    output logic cap_dr_o,
    output logic sh_dr_o,
    output logic up_dr_o,
    input wire logic tdo_i
);
    // quiet port: clock resting high, every state line low
    task automatic rest();
        tck_o = 1'b1;
        {tdi_o, tlr_o, cap_ir_o, sh_ir_o, up_ir_o, cap_dr_o, sh_dr_o, up_dr_o} = 8'h00;
    endtask
    // ==========================================
    // one tck cycle, states {tlr, cir, sir, uir, cdr, sdr, udr}; tck rests high
    task automatic step(input logic [6:0] st, input logic d, output logic o);
        {tlr_o, cap_ir_o, sh_ir_o, up_ir_o, cap_dr_o, sh_dr_o, up_dr_o} = st;
        tdi_o = d;
        #23 tck_o = 0;
        #23 o = tdo_i;
        #1 tck_o = 1;
        #1;
    endtask
    // released data line toggles so a stale value is never trusted
    task automatic idle(input int n);
        logic o;
        repeat (n) step(7'h00, ~tdi_o, o);
    endtask
    task automatic ir(input logic [3:0] v, output logic [3:0] q);
        logic o;
        step(7'h20, ~tdi_o, o);
        for (int i = 0; i < 4; i++)
            step(7'h10, v[i], q[i]);
        step(7'h00, ~tdi_o, o);
        step(7'h08, ~tdi_o, o);
        step(7'h00, ~tdi_o, o);
    endtask
    task automatic dr(input int n, input logic [34:0] v, output logic [34:0] q);
        logic o;
        q = '0;
        step(7'h04, ~tdi_o, o);
        for (int i = 0; i < n; i++)
            step(7'h02, v[i], q[i]);
        step(7'h00, ~tdi_o, o);
        step(7'h01, ~tdi_o, o);
        step(7'h00, ~tdi_o, o);
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench of the debug port scan chains
`timescale 1ns/1ps
`include "jdp_cfg.svh"

module tb_top
    import jdp_pkg::*;
;
    localparam logic [31:0] JT_V = 32'h0bad_c0de; // arbitrary
    localparam logic [31:0] ID_V = 32'h1234_5678; // arbitrary
    localparam logic [31:0] TG_V = 32'h7e57_0001; // arbitrary
    localparam logic [31:0] AP_V = 32'h5a5a_0f0f;
    logic clk_i = 0;
    logic rst_i = 1;
    logic ap_done_i = 0;
    jdp_resp_t ap_resp_i = '0;
    logic tck_i, serial_data_in_pin_i, tlr_i, capture_ir_i, shift_ir_i, update_ir_i;
    logic capture_dr_i, shift_dr_i, update_dr_i;
    logic serial_data_out_pin_o, serial_data_out_oe_o, ap_req_o, ap_abort_o;
    jdp_req_t ap_cmd_o, last_cmd;
    logic ap_err = 0;
    logic req_q = 0;
    int mismatches = 0, total_checks = 0, cycles = 0, cnt = 0;
    int ap_lat = 1, req_cnt = 0, abort_cnt = 0, n;
    logic [3:0] ir;
    logic [34:0] q;
    logic [3:0] bp [6] = '{4'hf, 4'h9, 4'hc, 4'hd, 4'h0, 4'h7};

    jdp_host jdp_host_i (.tck_o(tck_i), .tdi_o(serial_data_in_pin_i), .tlr_o(tlr_i),
        .cap_ir_o(capture_ir_i), .sh_ir_o(shift_ir_i), .up_ir_o(update_ir_i),
        .cap_dr_o(capture_dr_i), .sh_dr_o(shift_dr_i), .up_dr_o(update_dr_i),
        .tdo_i(serial_data_out_pin_o));
    jdp_scan #(.IDCODE_VAL(JT_V), .DP_ID_VAL(ID_V), .TARGET_ID_VAL(TG_V)) jdp_scan_i (
        .clk_i, .rst_i, .tck_i, .serial_data_in_pin_i, .tlr_i, .capture_ir_i, .shift_ir_i,
        .update_ir_i, .capture_dr_i, .shift_dr_i, .update_dr_i, .ap_done_i, .ap_resp_i,
        .serial_data_out_pin_o, .serial_data_out_oe_o, .ap_req_o, .ap_cmd_o, .ap_abort_o);

    always #50 clk_i = ~clk_i;
    // ==========================================
    // access port responder, done after ap_lat waiting cycles
    always @(posedge clk_i) begin
        #1;
        ap_done_i = ap_req_o && cnt >= ap_lat;
        if (ap_done_i) begin
            ap_resp_i = {ap_err, AP_V};
            last_cmd = ap_cmd_o;
        end
        cnt = ap_req_o && !ap_done_i ? cnt + 1 : 0;
        if (ap_req_o && !req_q)
            req_cnt++;
        req_q = ap_req_o;
        if (ap_abort_o)
            abort_cnt++;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // one access scan; m[0] checks the ack, m[1] the read data
    task automatic xs(input logic [34:0] v, input logic [2:0] a, input logic [31:0] d,
        input logic [1:0] m);
        logic [34:0] r;
        jdp_host_i.dr(35, v, r);
        if (m[0])
            chk("ack", {32'h0, a}, {32'h0, r[2:0]});
        if (m[1])
            chk("read data", {3'h0, d}, {3'h0, r[34:3]});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        jdp_host_i.rest();
        fork
            jdp_host_i.idle(10);
            begin
                repeat (4) @(posedge clk_i);
                #1 rst_i = 0;
            end
        join
        jdp_host_i.idle(4);
        jdp_host_i.dr(32, '0, q);
        chk("idcode", {3'h0, JT_V}, q);
        foreach (bp[k]) begin
            jdp_host_i.ir(bp[k], ir);
            chk("ir capture", 35'h1, {31'h0, ir});
            jdp_host_i.dr(9, 35'h0a5, q);
            chk("bypass", 35'h14a, q);
        end
        jdp_host_i.step(7'h40, 1'b0, q[0]);
        jdp_host_i.dr(32, '0, q);
        chk("idcode", {3'h0, JT_V}, q);
        $display("test instructions done");
        jdp_host_i.ir(`JDP_IR_DP_ACCESS_SCAN, ir);
        xs({32'h0, 2'h0, 1'b1}, 3'h4, 32'h0, 2'h1);
        xs({32'h0, 2'h3, 1'b1}, 3'h4, ID_V, 2'h3);
        xs({32'h2, 2'h2, 1'b0}, 3'h4, 32'h0, 2'h1);
        xs({32'h0, 2'h1, 1'b1}, 3'h4, 32'h0, 2'h1);
        xs({32'h0, 2'h3, 1'b1}, 3'h4, TG_V, 2'h3);
        xs({32'h0, 2'h2, 1'b0}, 3'h4, 32'h0, 2'h1);
        $display("test port registers done");
        jdp_host_i.ir(`JDP_IR_ACCESSPORT_ACCESS_CHAIN, ir);
        xs({32'hfeed_0001, 2'h1, 1'b0}, 3'h4, 32'h0, 2'h1);
        jdp_host_i.idle(20);
        chk("ap write", {32'hfeed_0001, 2'h1, 1'b0}, last_cmd);
        xs({32'h0, 2'h2, 1'b1}, 3'h4, 32'h0, 2'h1);
        jdp_host_i.idle(20);
        chk("ap read", {32'h0, 2'h2, 1'b1}, last_cmd);
        jdp_host_i.ir(`JDP_IR_DP_ACCESS_SCAN, ir);
        xs({32'h0, 2'h3, 1'b1}, 3'h4, AP_V, 2'h3);
        $display("test access port done");
        ap_lat = 200;
        jdp_host_i.ir(`JDP_IR_ACCESSPORT_ACCESS_CHAIN, ir);
        xs({32'h0, 2'h0, 1'b1}, 3'h4, 32'h0, 2'h1);
        xs({32'h0, 2'h1, 1'b1}, 3'h1, 32'h0, 2'h1);
        jdp_host_i.ir(`JDP_IR_ABORT, ir);
        jdp_host_i.dr(35, 35'h8, q);
        jdp_host_i.idle(20);
        chk("aborts", 35'h1, 35'(abort_cnt));
        chk("requests", 35'h3, 35'(req_cnt));
        ap_lat = 1;
        jdp_host_i.ir(`JDP_IR_DP_ACCESS_SCAN, ir);
        xs({32'h0, 2'h1, 1'b1}, 3'h0, 32'h0, 2'h0);
        xs({32'h0, 2'h3, 1'b1}, 3'h0, 32'h2, 2'h2);
        xs({32'h2, 2'h1, 1'b0}, 3'h0, 32'h0, 2'h0);
        $display("test wait and abort done");
        ap_err = 1;
        jdp_host_i.ir(`JDP_IR_ACCESSPORT_ACCESS_CHAIN, ir);
        xs({32'h1, 2'h0, 1'b0}, 3'h4, 32'h0, 2'h1);
        jdp_host_i.idle(20);
        ap_err = 0;
        n = req_cnt;
        xs({32'h1, 2'h0, 1'b0}, 3'h0, 32'h0, 2'h0);
        jdp_host_i.idle(20);
        chk("requests", 35'(n), 35'(req_cnt));
        xs({32'h1, 2'h0, 1'b0}, 3'h2, 32'h0, 2'h1);
        $display("test sticky error done");
        tally_and_finish();
    end
endmodule
